// ===== logic/tcm_pkg.sv
// Constants shared by the timer/counter block: addresses, fields, resets.
`default_nettype none
package tcm_pkg;
  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_TIMER_CONTROL_REG = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_REG    = 8'h89;
  localparam logic [7:0] ADDR_COUNT_LOW_A       = 8'h8A;
  localparam logic [7:0] ADDR_COUNT_LOW_B       = 8'h8B;
  localparam logic [7:0] ADDR_COUNT_HIGH_A      = 8'h8C;
  localparam logic [7:0] ADDR_COUNT_HIGH_B      = 8'h8D;
  localparam logic [7:0] ADDR_TIMER2_CONTROL    = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW_C      = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH_C     = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW_C       = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH_C      = 8'hCD;
  // Timer control register fields.
  localparam int TCR_FLAG_B = 7;
  localparam int TCR_RUN_B  = 6;
  localparam int TCR_FLAG_A = 5;
  localparam int TCR_RUN_A  = 4;
  // Timer mode register fields, timer a in the low nibble.
  localparam int TMR_GATE_B = 7;
  localparam int TMR_CT_B   = 6;
  localparam int TMR_MODE_B = 4;
  localparam int TMR_GATE_A = 3;
  localparam int TMR_CT_A   = 2;
  localparam int TMR_MODE_A = 0;
  // Timer 2 control fields.
  localparam int T2C_FLAG    = 7;
  localparam int T2C_EXT     = 6;
  localparam int T2C_RX_CLK  = 5;
  localparam int T2C_TX_CLK  = 4;
  localparam int T2C_EXT_EN  = 3;
  localparam int T2C_RUN     = 2;
  localparam int T2C_CNT_SEL = 1;
  localparam int T2C_CAP_SEL = 0;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Last core clock count of a machine cycle (twelve clocks).
  localparam logic [3:0] MC_LAST = 4'hB;
  // Operating modes of timers a and b.
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'h0,
    MODE_16BIT  = 2'h1,
    MODE_RELOAD = 2'h2,
    MODE_SPLIT  = 2'h3
  } tcm_mode_t;
endpackage
`default_nettype wire

// ===== logic/tcm_timer_counter_modes.sv
// Three timer/counters with their special function registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Mode 0 is a 13-bit up-counter.
// - Wrap from all ones sets overflow flag.
// - Timer a counts if run and gate satisfied.
// - 13-bit count is high byte plus five bits.
// - Setting run leaves counts unchanged.
// - Mode 1 counts the full 16 bits.
// - Mode 2 reloads low byte from high.
// - Timer b in mode 3 holds count.
// - Split mode: high byte uses b controls.
// - Timer b runs outside mode 3, feeds baud.
// - Timer 2 mode from clock, capture, run.
// - Autoreload rollover sets flag and reloads.
// - Trigger edge also reloads, sets external flag.
// - Capture mode overflow sets overflow flag.
// - Trigger edge captures count, sets external flag.
// - Baud mode never sets timer 2 overflow.
// - External flag still works in baud mode.
// - Clock selects force autoreload on overflow.
// - Trigger ignored when disabled; in baud mode it only sets external flag.
// - Clock selects route timer 2 or b ticks.
// - Counter select picks pin; run starts timer.
// - Mode 0 low bits prescale by 32.
// - Vectoring clears timer a and b flags.
// - Counter select picks pin or clock.
module tcm_timer_counter_modes (
  // Clock, reset, enable
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  // Special function register port
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  // Interrupt vector acknowledges from the core
  input  wire logic       i_vector_ack_a,
  input  wire logic       i_vector_ack_b,
  // Pins
  input  wire logic       i_ext_interrupt_input_a,
  input  wire logic       i_ext_interrupt_input_b,
  input  wire logic       i_count_pin_a,
  input  wire logic       i_count_pin_b,
  input  wire logic       i_count_input_c,
  input  wire logic       i_capture_trigger_input,
  // Flags and serial clock ticks
  output logic            o_overflow_flag_a,
  output logic            o_overflow_flag_b,
  output logic            o_overflow_flag_c,
  output logic            o_external_flag_c,
  output logic            o_rx_baud_tick,
  output logic            o_tx_baud_tick
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] timer_mode_reg_q;
  logic       run_a_q;
  logic       run_b_q;
  logic [7:0] tl_a_q, th_a_q, tl_b_q, th_b_q;
  logic [7:0] tl_a_d, th_a_d, tl_b_d, th_b_d;
  logic [7:0] timer2_control_q;
  logic [7:0] tl_c_q, th_c_q, rl_c_q, rh_c_q;
  logic [7:0] tl_c_d, th_c_d;
  logic [3:0] mc_q;
  logic       mtick;
  logic [5:0] sync1_q, sync2_q, prev_q;
  logic [5:0] fall;
  logic       ovf_a, ovf_ah, ovf_b, ovf_c, ext_c;
  logic       inc_a, inc_b, inc_ah, inc_c;
  logic       baud, split_a, wr_tcr, wr_t2c;
  tcm_pkg::tcm_mode_t mode_a, mode_b;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_sfr_wr && (i_sfr_addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous, so each passes two flops before any logic.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      prev_q  <= 6'h00;
    end else if (i_clk_en) begin
      sync1_q <= {i_capture_trigger_input, i_count_input_c, i_count_pin_b,
                  i_count_pin_a, i_ext_interrupt_input_b,
                  i_ext_interrupt_input_a};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign fall = prev_q & ~sync2_q;

  // Machine cycle divider of twelve core clocks.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mc_q <= 4'h0;
    end else if (i_clk_en) begin
      mc_q <= (mc_q == tcm_pkg::MC_LAST) ? 4'h0 : mc_q + 4'h1;
    end
  end

  assign mtick = (mc_q == tcm_pkg::MC_LAST);

  ////////////////////////////////////////////////////////////////////////////
  assign mode_a  = tcm_pkg::tcm_mode_t'(timer_mode_reg_q[tcm_pkg::TMR_MODE_A +: 2]);
  assign mode_b  = tcm_pkg::tcm_mode_t'(timer_mode_reg_q[tcm_pkg::TMR_MODE_B +: 2]);
  assign split_a = (mode_a == tcm_pkg::MODE_SPLIT);
  assign wr_tcr  = wr_at(tcm_pkg::ADDR_TIMER_CONTROL_REG);
  assign wr_t2c  = wr_at(tcm_pkg::ADDR_TIMER2_CONTROL);

  assign inc_a = run_a_q && (!timer_mode_reg_q[tcm_pkg::TMR_GATE_A] || sync2_q[0])
    && (timer_mode_reg_q[tcm_pkg::TMR_CT_A] ? fall[2] : mtick);
  // While timer a is split, timer b loses its run bit and runs freely.
  assign inc_b = (split_a || run_b_q) && (mode_b != tcm_pkg::MODE_SPLIT)
    && (!timer_mode_reg_q[tcm_pkg::TMR_GATE_B] || sync2_q[1])
    && (timer_mode_reg_q[tcm_pkg::TMR_CT_B] ? fall[3] : mtick);
  assign inc_ah = split_a && run_b_q && mtick;

  always_comb begin
    tl_a_d = tl_a_q;
    th_a_d = th_a_q;
    ovf_a  = 1'b0;
    ovf_ah = 1'b0;
    if (inc_a) begin
      case (mode_a)
        tcm_pkg::MODE_13BIT: begin
          {th_a_d, tl_a_d[4:0]} = {th_a_q, tl_a_q[4:0]} + 13'h0001;
          ovf_a = &{th_a_q, tl_a_q[4:0]};
        end
        tcm_pkg::MODE_16BIT: begin
          {th_a_d, tl_a_d} = {th_a_q, tl_a_q} + 16'h0001;
          ovf_a = &{th_a_q, tl_a_q};
        end
        tcm_pkg::MODE_RELOAD: begin
          tl_a_d = (&tl_a_q) ? th_a_q : tl_a_q + 8'h01;
          ovf_a  = &tl_a_q;
        end
        default: begin
          tl_a_d = tl_a_q + 8'h01;
          ovf_a  = &tl_a_q;
        end
      endcase
    end
    if (inc_ah) begin
      th_a_d = th_a_q + 8'h01;
      ovf_ah = &th_a_q;
    end
  end

  always_comb begin
    tl_b_d = tl_b_q;
    th_b_d = th_b_q;
    ovf_b  = 1'b0;
    if (inc_b) begin
      case (mode_b)
        tcm_pkg::MODE_13BIT: begin
          {th_b_d, tl_b_d[4:0]} = {th_b_q, tl_b_q[4:0]} + 13'h0001;
          ovf_b = &{th_b_q, tl_b_q[4:0]};
        end
        tcm_pkg::MODE_16BIT: begin
          {th_b_d, tl_b_d} = {th_b_q, tl_b_q} + 16'h0001;
          ovf_b = &{th_b_q, tl_b_q};
        end
        tcm_pkg::MODE_RELOAD: begin
          tl_b_d = (&tl_b_q) ? th_b_q : tl_b_q + 8'h01;
          ovf_b  = &tl_b_q;
        end
        default: begin
          ovf_b = 1'b0;
        end
      endcase
    end
  end

  // Count registers; a software write wins over a count in the same cycle.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tl_a_q <= tcm_pkg::RST_BYTE;
      th_a_q <= tcm_pkg::RST_BYTE;
      tl_b_q <= tcm_pkg::RST_BYTE;
      th_b_q <= tcm_pkg::RST_BYTE;
    end else if (i_clk_en) begin
      tl_a_q <= wr_at(tcm_pkg::ADDR_COUNT_LOW_A) ? i_sfr_wdata : tl_a_d;
      th_a_q <= wr_at(tcm_pkg::ADDR_COUNT_HIGH_A) ? i_sfr_wdata : th_a_d;
      tl_b_q <= wr_at(tcm_pkg::ADDR_COUNT_LOW_B) ? i_sfr_wdata : tl_b_d;
      th_b_q <= wr_at(tcm_pkg::ADDR_COUNT_HIGH_B) ? i_sfr_wdata : th_b_d;
    end
  end

  // Control bits; a hardware set wins over any clear in the same cycle.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_mode_reg_q            <= tcm_pkg::RST_BYTE;
      run_a_q           <= 1'b0;
      run_b_q           <= 1'b0;
      o_overflow_flag_a <= 1'b0;
      o_overflow_flag_b <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_at(tcm_pkg::ADDR_TIMER_MODE_REG)) begin
        timer_mode_reg_q <= i_sfr_wdata;
      end
      if (wr_tcr) begin
        run_a_q <= i_sfr_wdata[tcm_pkg::TCR_RUN_A];
        run_b_q <= i_sfr_wdata[tcm_pkg::TCR_RUN_B];
      end
      if (ovf_a) begin
        o_overflow_flag_a <= 1'b1;
      end else if (wr_tcr) begin
        o_overflow_flag_a <= i_sfr_wdata[tcm_pkg::TCR_FLAG_A];
      end else if (i_vector_ack_a) begin
        o_overflow_flag_a <= 1'b0;
      end
      if (split_a ? ovf_ah : ovf_b) begin
        o_overflow_flag_b <= 1'b1;
      end else if (wr_tcr) begin
        o_overflow_flag_b <= i_sfr_wdata[tcm_pkg::TCR_FLAG_B];
      end else if (i_vector_ack_b) begin
        o_overflow_flag_b <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign baud  = timer2_control_q[tcm_pkg::T2C_RX_CLK] | timer2_control_q[tcm_pkg::T2C_TX_CLK];
  assign inc_c = timer2_control_q[tcm_pkg::T2C_RUN] && (timer2_control_q[tcm_pkg::T2C_CNT_SEL]
    ? fall[4] : mtick);
  assign ovf_c = inc_c && (&{th_c_q, tl_c_q});
  assign ext_c = timer2_control_q[tcm_pkg::T2C_EXT_EN] && fall[5];

  always_comb begin
    {th_c_d, tl_c_d} = {th_c_q, tl_c_q};
    if (inc_c) begin
      {th_c_d, tl_c_d} = {th_c_q, tl_c_q} + 16'h0001;
    end
    // Reload on overflow unless capturing; baud mode forces reload.
    if ((ovf_c || (ext_c && !baud))
        && (!timer2_control_q[tcm_pkg::T2C_CAP_SEL] || baud)) begin
      {th_c_d, tl_c_d} = {rh_c_q, rl_c_q};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tl_c_q <= tcm_pkg::RST_BYTE;
      th_c_q <= tcm_pkg::RST_BYTE;
      rl_c_q <= tcm_pkg::RST_BYTE;
      rh_c_q <= tcm_pkg::RST_BYTE;
    end else if (i_clk_en) begin
      tl_c_q <= wr_at(tcm_pkg::ADDR_COUNT_LOW_C) ? i_sfr_wdata : tl_c_d;
      th_c_q <= wr_at(tcm_pkg::ADDR_COUNT_HIGH_C) ? i_sfr_wdata : th_c_d;
      if (wr_at(tcm_pkg::ADDR_RELOAD_LOW_C)) begin
        rl_c_q <= i_sfr_wdata;
      end else if (ext_c && !baud && timer2_control_q[tcm_pkg::T2C_CAP_SEL]) begin
        rl_c_q <= tl_c_q;
      end
      if (wr_at(tcm_pkg::ADDR_RELOAD_HIGH_C)) begin
        rh_c_q <= i_sfr_wdata;
      end else if (ext_c && !baud && timer2_control_q[tcm_pkg::T2C_CAP_SEL]) begin
        rh_c_q <= th_c_q;
      end
    end
  end

  // The two flags are never cleared by hardware; software owns the clear.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      timer2_control_q <= tcm_pkg::RST_BYTE;
    end else if (i_clk_en) begin
      if (wr_t2c) begin
        timer2_control_q <= i_sfr_wdata;
      end
      if (ovf_c && !baud) begin
        timer2_control_q[tcm_pkg::T2C_FLAG] <= 1'b1;
      end
      if (ext_c) begin
        timer2_control_q[tcm_pkg::T2C_EXT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag and tick outputs are flops so the core sees clean levels.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_overflow_flag_c <= 1'b0;
      o_external_flag_c <= 1'b0;
      o_rx_baud_tick    <= 1'b0;
      o_tx_baud_tick    <= 1'b0;
    end else if (i_clk_en) begin
      o_overflow_flag_c <= timer2_control_q[tcm_pkg::T2C_FLAG];
      o_external_flag_c <= timer2_control_q[tcm_pkg::T2C_EXT];
      o_rx_baud_tick <= timer2_control_q[tcm_pkg::T2C_RX_CLK] ? ovf_c : ovf_b;
      o_tx_baud_tick <= timer2_control_q[tcm_pkg::T2C_TX_CLK] ? ovf_c : ovf_b;
    end
  end

  // Read data follows a read strobe by one cycle; unmapped reads give zero.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_clk_en && i_sfr_rd) begin
      case (i_sfr_addr)
        tcm_pkg::ADDR_TIMER_CONTROL_REG:
          o_sfr_rdata <= {o_overflow_flag_b, run_b_q, o_overflow_flag_a,
                          run_a_q, 4'h0};
        tcm_pkg::ADDR_TIMER_MODE_REG: o_sfr_rdata <= timer_mode_reg_q;
        tcm_pkg::ADDR_COUNT_LOW_A:    o_sfr_rdata <= tl_a_q;
        tcm_pkg::ADDR_COUNT_LOW_B:    o_sfr_rdata <= tl_b_q;
        tcm_pkg::ADDR_COUNT_HIGH_A:   o_sfr_rdata <= th_a_q;
        tcm_pkg::ADDR_COUNT_HIGH_B:   o_sfr_rdata <= th_b_q;
        tcm_pkg::ADDR_TIMER2_CONTROL: o_sfr_rdata <= timer2_control_q;
        tcm_pkg::ADDR_RELOAD_LOW_C:   o_sfr_rdata <= rl_c_q;
        tcm_pkg::ADDR_RELOAD_HIGH_C:  o_sfr_rdata <= rh_c_q;
        tcm_pkg::ADDR_COUNT_LOW_C:    o_sfr_rdata <= tl_c_q;
        tcm_pkg::ADDR_COUNT_HIGH_C:   o_sfr_rdata <= th_c_q;
        default:                      o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic wr_cnt_a, wr_cnt_b, wr_cnt_c;
  assign wr_cnt_a = wr_at(tcm_pkg::ADDR_COUNT_LOW_A)
                  || wr_at(tcm_pkg::ADDR_COUNT_HIGH_A);
  assign wr_cnt_b = wr_at(tcm_pkg::ADDR_COUNT_LOW_B)
                  || wr_at(tcm_pkg::ADDR_COUNT_HIGH_B);
  assign wr_cnt_c = wr_at(tcm_pkg::ADDR_COUNT_LOW_C)
                  || wr_at(tcm_pkg::ADDR_COUNT_HIGH_C);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  property p_mode0_carry;
    i_clk_en && inc_a && mode_a == tcm_pkg::MODE_13BIT
      && tl_a_q[4:0] == 5'h1F && !wr_cnt_a
      |=> th_a_q == $past(th_a_q) + 8'h01 && tl_a_q[4:0] == 5'h00;
  endproperty
  a_mode0_carry: assert property (p_mode0_carry)
    else $error("Mode 0 prescaler carry into high byte failed.");

  property p_mode1_flag;
    i_clk_en && mode_a == tcm_pkg::MODE_16BIT && inc_a
      && {th_a_q, tl_a_q} == 16'hFFFF && !wr_cnt_a
      |=> o_overflow_flag_a && {th_a_q, tl_a_q} == 16'h0000;
  endproperty
  a_mode1_flag: assert property (p_mode1_flag)
    else $error("Mode 1 wrap did not set flag and clear count.");

  property p_gate_hold;
    i_clk_en && run_a_q && timer_mode_reg_q[tcm_pkg::TMR_GATE_A] && !sync2_q[0]
      && !wr_cnt_a |=> $stable(tl_a_q) && ($past(split_a) || $stable(th_a_q));
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("Gated timer a counted while interrupt input low.");

  property p_mode2_reload;
    i_clk_en && mode_a == tcm_pkg::MODE_RELOAD && inc_a && tl_a_q == 8'hFF
      && !wr_cnt_a |=> tl_a_q == $past(th_a_q) && $stable(th_a_q);
  endproperty
  a_mode2_reload: assert property (p_mode2_reload)
    else $error("Mode 2 low byte did not reload from high byte.");

  property p_b_split_hold;
    i_clk_en && mode_b == tcm_pkg::MODE_SPLIT && !wr_cnt_b
      |=> $stable(tl_b_q) && $stable(th_b_q);
  endproperty
  a_b_split_hold: assert property (p_b_split_hold)
    else $error("Timer b counted while in mode 3.");

  property p_c_reload;
    i_clk_en && ovf_c && (!timer2_control_q[tcm_pkg::T2C_CAP_SEL] || baud)
      && !wr_cnt_c |=> {th_c_q, tl_c_q} == $past({rh_c_q, rl_c_q});
  endproperty
  a_c_reload: assert property (p_c_reload)
    else $error("Timer 2 overflow did not reload count.");

  property p_c_capture;
    i_clk_en && ext_c && !baud && timer2_control_q[tcm_pkg::T2C_CAP_SEL]
      && !wr_at(tcm_pkg::ADDR_RELOAD_LOW_C)
      && !wr_at(tcm_pkg::ADDR_RELOAD_HIGH_C)
      |=> {rh_c_q, rl_c_q} == $past({th_c_q, tl_c_q})
      ##1 o_external_flag_c;
  endproperty
  a_c_capture: assert property (p_c_capture)
    else $error("Timer 2 capture or external flag missing.");

  property p_baud_no_flag;
    i_clk_en && baud && !timer2_control_q[tcm_pkg::T2C_FLAG] && !wr_t2c
      |=> !timer2_control_q[tcm_pkg::T2C_FLAG];
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("Timer 2 overflow flag set in baud mode.");

  property p_ack_clear;
    i_clk_en && i_vector_ack_a && !ovf_a && !wr_tcr |=> !o_overflow_flag_a;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("Vector acknowledge did not clear timer a flag.");

  property p_tx_route;
    i_clk_en && timer2_control_q[tcm_pkg::T2C_TX_CLK]
      |=> o_tx_baud_tick == $past(ovf_c);
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("Transmit tick not taken from timer 2 overflow.");

  c_split_both: cover property (i_clk_en && split_a && ovf_a ##[1:300] ovf_ah);
  c_capture: cover property (i_clk_en && ext_c
    && timer2_control_q[tcm_pkg::T2C_CAP_SEL]);
  c_baud_ext: cover property (i_clk_en && baud && ext_c);
  c_mode0_wrap: cover property (ovf_a && mode_a == tcm_pkg::MODE_13BIT);

endmodule
`default_nettype wire

// ===== dv/tcm_core_model.sv
// Processor core model that drives the timer special function register port.
`timescale 1ns/1ps
`default_nettype none
module tcm_core_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Register port toward the timers
  output logic      [7:0] o_sfr_addr,
  output logic            o_sfr_wr,
  output logic      [7:0] o_sfr_wdata,
  output logic            o_sfr_rd,
  input  wire logic [7:0] i_sfr_rdata,
  // Interrupt vector acknowledges
  output logic            o_vector_ack_a,
  output logic            o_vector_ack_b
);
  initial begin
    o_sfr_addr = 8'h00;
    o_sfr_wr = 1'b0;
    o_sfr_wdata = 8'h00;
    o_sfr_rd = 1'b0;
    o_vector_ack_a = 1'b0;
    o_vector_ack_b = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Released write data shows its inverse so a stale byte cannot pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_sfr_addr = a;
    o_sfr_wdata = d;
    o_sfr_wr = 1'b1;
    @(negedge i_sys_clk);
    o_sfr_wr = 1'b0;
    o_sfr_wdata = ~d;
  endtask
  // Read data is registered, so it is taken one cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_sfr_addr = a;
    o_sfr_rd = 1'b1;
    @(negedge i_sys_clk);
    o_sfr_rd = 1'b0;
    @(negedge i_sys_clk);
    d = i_sfr_rdata;
  endtask
  // Timer 2 flags are cleared only by software; this write zeroes both flag bits.
  task automatic clr_t2(input logic [7:0] a, input logic [7:0] ctl);
    wr(a, ctl & 8'h3F);
  endtask
  task automatic ack(input logic sel);
    @(negedge i_sys_clk);
    o_vector_ack_a = ~sel;
    o_vector_ack_b = sel;
    @(negedge i_sys_clk);
    o_vector_ack_a = 1'b0;
    o_vector_ack_b = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/tcm_timer_counter_modes_test.sv
// Self-checking testbench for the three timer/counters.
`timescale 1ns/1ps
`default_nettype none
module tcm_timer_counter_modes_test;
  logic        clk, rst, ce, int_a, rxt, txt, fa, fb, fc, ec;
  logic [7:0]  addr, wdata, rdata, b;
  logic        wr, rd, ack_a, ack_b;
  logic [3:0]  pins;
  logic [15:0] v, c, rl;
  logic [31:0] rv;
  int          err_total, compares, seed, rx_n, tx_n;
  logic [7:0]  hi_ad [4] = '{tcm_pkg::ADDR_COUNT_HIGH_A,
    tcm_pkg::ADDR_COUNT_HIGH_B, tcm_pkg::ADDR_COUNT_HIGH_C,
    tcm_pkg::ADDR_RELOAD_HIGH_C};
  logic [7:0]  lo_ad [4] = '{tcm_pkg::ADDR_COUNT_LOW_A,
    tcm_pkg::ADDR_COUNT_LOW_B, tcm_pkg::ADDR_COUNT_LOW_C,
    tcm_pkg::ADDR_RELOAD_LOW_C};
  logic [7:0]  ct_ad [3] = '{tcm_pkg::ADDR_TIMER_CONTROL_REG,
    tcm_pkg::ADDR_TIMER_MODE_REG, tcm_pkg::ADDR_TIMER2_CONTROL};
  ////////////////////////////////////////////////////////////////////////////
  tcm_timer_counter_modes dut_u (.i_sys_clk(clk), .i_reset(rst),
    .i_clk_en(ce), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_vector_ack_a(ack_a),
    .i_vector_ack_b(ack_b), .i_ext_interrupt_input_a(int_a),
    .i_ext_interrupt_input_b(1'b0), .i_count_pin_a(pins[0]),
    .i_count_pin_b(pins[1]), .i_count_input_c(pins[2]),
    .i_capture_trigger_input(pins[3]), .o_overflow_flag_a(fa),
    .o_overflow_flag_b(fb), .o_overflow_flag_c(fc), .o_external_flag_c(ec),
    .o_rx_baud_tick(rxt), .o_tx_baud_tick(txt));
  tcm_core_model core_u (.i_sys_clk(clk), .o_sfr_addr(addr), .o_sfr_wr(wr),
    .o_sfr_wdata(wdata), .o_sfr_rd(rd), .i_sfr_rdata(rdata),
    .o_vector_ack_a(ack_a), .o_vector_ack_b(ack_b));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxt === 1'b1) rx_n = rx_n + 1;
    if (txt === 1'b1) tx_n = tx_n + 1;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic set16(input int t, input logic [15:0] val);
    core_u.wr(hi_ad[t], val[15:8]);
    core_u.wr(lo_ad[t], val[7:0]);
  endtask
  task automatic get16(input int t, output logic [15:0] val);
    core_u.rd(hi_ad[t], val[15:8]);
    core_u.rd(lo_ad[t], val[7:0]);
  endtask
  // Pins idle high and each level holds three cycles, above the sync need.
  task automatic fall(input int p, input int n);
    repeat (n) begin
      @(negedge clk);
      pins[p] = 1'b0;
      repeat (3) @(negedge clk);
      pins[p] = 1'b1;
      repeat (3) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [15:0] t2_next(input logic [15:0] cv,
      input logic [15:0] r, input logic cap);
    if (cv != 16'hFFFF) return cv + 16'h0001;
    return cap ? 16'h0000 : r;
  endfunction
  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    int_a = 1'b0;
    pins = 4'hF;
    err_total = 0;
    compares = 0;
    seed = 2;
    rx_n = 0;
    tx_n = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int t = 0; t < 4; t++) begin
      get16(t, v);
      chk(v, 16'h0000);
    end
    for (int t = 0; t < 3; t++) begin
      core_u.rd(ct_ad[t], b);
      chk(b, 8'h00);
    end
    core_u.wr(8'h90, 8'hFF);
    core_u.rd(8'h90, b);
    chk(b, 8'h00);
    core_u.wr(ct_ad[0], 8'h0F);
    core_u.rd(ct_ad[0], b);
    chk(b, 8'h00);
    // Timer a in counter function: 16 bits, gate, 13 bits, reload.
    core_u.wr(ct_ad[1], 8'h05);
    set16(0, 16'hFFFE);
    fall(0, 2);
    get16(0, v);
    chk(v, 16'hFFFE);
    core_u.wr(ct_ad[0], 8'h10);
    get16(0, v);
    chk(v, 16'hFFFE);
    fall(0, 2);
    get16(0, v);
    chk(v, 16'h0000);
    chk(fa, 1'b1);
    core_u.ack(1'b0);
    chk(fa, 1'b0);
    core_u.wr(ct_ad[1], 8'h0D);
    fall(0, 1);
    get16(0, v);
    chk(v, 16'h0000);
    int_a = 1'b1;
    fall(0, 1);
    get16(0, v);
    chk(v, 16'h0001);
    core_u.wr(ct_ad[1], 8'h04);
    set16(0, 16'h001F);
    fall(0, 1);
    get16(0, v);
    chk({v[15:8], 3'h0, v[4:0]}, 16'h0100);
    set16(0, 16'hFFFF);
    fall(0, 1);
    get16(0, v);
    chk({v[15:8], 3'h0, v[4:0]}, 16'h0000);
    chk(fa, 1'b1);
    core_u.wr(ct_ad[1], 8'h06);
    set16(0, 16'hA5FF);
    fall(0, 1);
    get16(0, v);
    chk(v, 16'hA5A5);
    // Split timer a: high byte runs on machine cycles with run b.
    core_u.wr(ct_ad[1], 8'h07);
    set16(0, 16'hFF00);
    core_u.wr(ct_ad[0], 8'h50);
    fall(0, 1);
    get16(0, v);
    chk(v[7:0], 8'h01);
    chk(fb, 1'b1);
    core_u.wr(ct_ad[1], 8'h57);
    set16(1, 16'h0000);
    fall(1, 1);
    get16(1, v);
    chk(v, 16'h0001);
    core_u.wr(ct_ad[1], 8'h77);
    fall(1, 1);
    get16(1, v);
    chk(v, 16'h0001);
    core_u.wr(ct_ad[0], 8'h00);
    // Timer 2 reload and capture from random values.
    for (int i = 0; i < 8; i++) begin
      rv = $random(seed);
      rl = rv[15:0];
      rv = $random(seed);
      c = i[0] ? 16'hFFFF : rv[15:0];
      core_u.wr(ct_ad[2], 8'h00);
      set16(3, rl);
      set16(2, c);
      core_u.wr(ct_ad[2], {7'h03, i[1]});
      fall(2, 1);
      get16(2, v);
      chk(v, t2_next(c, rl, i[1]));
      core_u.rd(ct_ad[2], b);
      chk(b[7], c == 16'hFFFF);
    end
    repeat (20) @(negedge clk);
    chk(fc, 1'b1);
    core_u.clr_t2(ct_ad[2], 8'h0E);
    set16(3, 16'h1234);
    set16(2, 16'h0050);
    fall(3, 1);
    get16(2, v);
    chk(v, 16'h1234);
    core_u.rd(ct_ad[2], b);
    chk(b, 8'h4E);
    chk(ec, 1'b1);
    core_u.wr(ct_ad[2], 8'h0F);
    set16(2, 16'h5566);
    fall(3, 1);
    get16(3, v);
    chk(v, 16'h5566);
    get16(2, v);
    chk(v, 16'h5566);
    core_u.wr(ct_ad[2], 8'h07);
    set16(3, 16'h0000);
    fall(3, 1);
    get16(3, v);
    chk(v, 16'h0000);
    core_u.wr(ct_ad[2], 8'h02);
    set16(2, 16'h0010);
    fall(2, 3);
    get16(2, v);
    chk(v, 16'h0010);
    // A low clock enable freezes the pin samplers, so no edge is seen.
    core_u.wr(ct_ad[2], 8'h06);
    ce = 1'b0;
    fall(2, 2);
    ce = 1'b1;
    get16(2, v);
    chk(v, 16'h0010);
    set16(2, 16'h0000);
    core_u.wr(ct_ad[2], 8'h04);
    repeat (40) @(negedge clk);
    core_u.wr(ct_ad[2], 8'h00);
    get16(2, v);
    chk(v >= 16'h0003 && v <= 16'h0004, 1'b1);
    // Baud mode ignores the capture select and never raises overflow.
    core_u.wr(ct_ad[2], 8'h37);
    set16(3, 16'h1234);
    set16(2, 16'hFFFF);
    rx_n = 0;
    tx_n = 0;
    fall(2, 1);
    get16(2, v);
    chk(v, 16'h1234);
    chk(rx_n, 1);
    chk(tx_n, 1);
    core_u.rd(ct_ad[2], b);
    chk(b, 8'h37);
    chk(fc, 1'b0);
    core_u.wr(ct_ad[2], 8'h3F);
    fall(3, 1);
    core_u.rd(ct_ad[2], b);
    chk(b, 8'h7F);
    get16(2, v);
    chk(v, 16'h1234);
    core_u.wr(ct_ad[2], 8'h00);
    core_u.wr(ct_ad[1], 8'h50);
    set16(1, 16'hFFFF);
    core_u.wr(ct_ad[0], 8'h40);
    rx_n = 0;
    tx_n = 0;
    fall(1, 1);
    chk(rx_n, 1);
    chk(tx_n, 1);
    chk(fb, 1'b1);
    core_u.ack(1'b1);
    chk(fb, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
